// File: core/lsc_regs.sv
// Strobed register access was left to the implementer.
`timescale 1ns/100ps
`include "lsc_map.svh"
module lsc_regs import lsc_pkg::*; #(
	parameter int BASE_CYC = `LSC_BASE_CYC,
	parameter int FAST_CYC = `LSC_FAST_CYC,
	parameter int FASTLONG_CYC = `LSC_FASTLONG_CYC,
	parameter int NORMAL_CYC = `LSC_NORMAL_CYC,
	parameter int LONG_CYC = `LSC_LONG_CYC
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic [3:0] gain_request,
	input wire logic predict_mode,
	output logic [3:0] gain_applied,
	input wire logic [23:0] flicker_raw,
	output logic [23:0] flicker_word,
	input wire logic [7:0] sample_period,
	input wire logic agc_start,
	output logic agc_busy,
	input wire logic oscillator_power_on,
	input wire logic meas_enable,
	input wire logic vsync_start_sel,
	input wire logic vsync_pulse,
	input wire logic [7:0] wait_step_count,
	output logic repeat_tick,
	output logic queue_flush,
	output logic wake_from_irq_sleep,
	output logic measure_restart,
	output logic soft_reset_req
);
	lsc_cfg_type cfg_q, cfg_d;
	lsc_state_type st_q, st_d;
	logic [7:0] rdata_q, rdata_d;
	logic [39:0] unit_q, unit_d;
	logic [7:0] step_q, step_d;
	logic [19:0] agc_q, agc_d;
	logic [1:0] cmd_q, cmd_d;
	logic srst_q, srst_d;
	logic restart_q, restart_d;
	logic [7:0] base_q, base_d;
	logic [39:0] unit_len;
	logic [19:0] agc_len;
	logic wr_cmd;

	// soft reset acts next cycle as a synchronous clear of the configuration, command bits, sequencer state and auto-gain count
	assign wr_cmd = wr_en && addr == `LSC_OFF_CMD;
	assign soft_reset_req = srst_q;

	// register writes and read mux; read data only in the cycle after the strobe
	always_comb
	begin
		cfg_d = cfg_q;
		rdata_d = 8'h00;
		srst_d = 1'b0;
		cmd_d = 2'b00;
		if (wr_en)
		begin
			case (addr)
				`LSC_OFF_GAIN: {cfg_d.max_gain, cfg_d.gain_reduction} = wdata;
				`LSC_OFF_RESID: cfg_d.dropped_residual_count = wdata[1:0];
				`LSC_OFF_AGC_LO: cfg_d.auto_gain_sample_count[7:0] = wdata;
				`LSC_OFF_AGC_HI: cfg_d.auto_gain_sample_count[10:8] = wdata[2:0];
				`LSC_OFF_REPEAT: cfg_d.repeat_rate_select = lsc_rate_type'(wdata[2:0]);
				default: cfg_d = cfg_q;
			endcase
		end
		if (wr_cmd)
		begin
			// soft reset only honoured while the oscillator runs; flush and wake are taken regardless
			srst_d = wdata[`LSC_CMD_SOFT_RESET] && oscillator_power_on;
			cmd_d = {wdata[`LSC_CMD_QUEUE_FLUSH], wdata[`LSC_CMD_WAKE]};
		end
		if (rd_en)
		begin
			case (addr)
				`LSC_OFF_GAIN: rdata_d = {cfg_q.max_gain, cfg_q.gain_reduction};
				`LSC_OFF_RESID: rdata_d = {6'h00, cfg_q.dropped_residual_count};
				`LSC_OFF_AGC_LO: rdata_d = cfg_q.auto_gain_sample_count[7:0];
				`LSC_OFF_AGC_HI: rdata_d = {5'h00, cfg_q.auto_gain_sample_count[10:8]};
				`LSC_OFF_REPEAT: rdata_d = {5'h00, cfg_q.repeat_rate_select};
				`LSC_OFF_CMD: rdata_d = {4'h0, srst_q, 1'b0, cmd_q};
				default: rdata_d = 8'h00;
			endcase
		end
		if (srst_q)
		begin
			cfg_d = '{`LSC_RST_MAX_GAIN, `LSC_RST_GAIN_RED, 2'h0, 11'h000, LSC_RATE_OFF};
			cmd_d = 2'b00;
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cfg_q <= '{`LSC_RST_MAX_GAIN, `LSC_RST_GAIN_RED, 2'h0, 11'h000, LSC_RATE_OFF};
			rdata_q <= 8'h00;
			srst_q <= 1'b0;
			cmd_q <= 2'b00;
		end
		else
		begin
			cfg_q <= cfg_d;
			rdata_q <= rdata_d;
			srst_q <= srst_d;
			cmd_q <= cmd_d;
		end
	end

	assign rdata = rdata_q;
	assign queue_flush = cmd_q[1];
	assign wake_from_irq_sleep = cmd_q[0];
	assign measure_restart = restart_q;

	// gain: reduce first in predict mode, then cap at the ceiling
	always_comb
	begin
		logic [3:0] g;
		g = gain_request;
		if (predict_mode)
			g = (gain_request > cfg_q.gain_reduction) ?
				gain_request - cfg_q.gain_reduction : 4'h0;
		gain_applied = (g > cfg_q.max_gain) ? cfg_q.max_gain : g;
	end

	// residual bits shifted out; queue width is software's concern
	assign flicker_word = flicker_raw >> cfg_q.dropped_residual_count;

	// auto-gain time in base units; each unit is BASE_CYC cycles
	assign agc_len = 20'((cfg_q.auto_gain_sample_count + 12'h001) *
		(sample_period + 9'h001));
	assign agc_busy = agc_q != 20'h00000;

	// repetition unit length per rate code
	always_comb
	begin
		case (cfg_q.repeat_rate_select)
			LSC_RATE_NORMAL: unit_len = 40'(NORMAL_CYC);
			LSC_RATE_LONG: unit_len = 40'(LONG_CYC);
			LSC_RATE_FAST: unit_len = 40'(FAST_CYC);
			LSC_RATE_FASTLONG: unit_len = 40'(FASTLONG_CYC);
			default: unit_len = 40'h1;
		endcase
	end

	// repetition sequencer; reserved codes behave as off
	always_comb
	begin
		logic unit_done;
		logic vs_mode;
		logic off;
		unit_done = 1'b0;
		vs_mode = cfg_q.repeat_rate_select == LSC_RATE_VSYNC;
		off = cfg_q.repeat_rate_select == LSC_RATE_OFF ||
			cfg_q.repeat_rate_select == LSC_RATE_RSV6 ||
			cfg_q.repeat_rate_select == LSC_RATE_RSV7;
		st_d = st_q;
		unit_d = unit_q;
		step_d = step_q;
		repeat_tick = 1'b0;
		restart_d = cmd_q[0] && meas_enable;
		agc_d = agc_q;
		// auto-gain countdown steps once per base unit; a start only loads when idle
		if (agc_q != 20'h00000 && base_q + 8'h01 >= 8'(BASE_CYC))
			agc_d = agc_q - 20'h00001;
		else if (agc_start && agc_q == 20'h00000)
			agc_d = agc_len;
		case (st_q)
			LSC_IDLE:
			begin
				if (!off && meas_enable)
					st_d = (vsync_start_sel || vs_mode) ? LSC_ARM : LSC_COUNT;
				unit_d = 40'h0;
				step_d = 8'h00;
			end
			LSC_ARM:
			begin
				if (vsync_pulse)
					st_d = LSC_COUNT;
			end
			LSC_COUNT:
			begin
				if (vs_mode)
					unit_done = vsync_pulse;
				else if (unit_q + 40'h1 >= unit_len)
					unit_done = 1'b1;
				unit_d = unit_done ? 40'h0 : unit_q + 40'h1;
				if (unit_done)
				begin
					if (step_q + 8'h01 >= wait_step_count)
					begin
						step_d = 8'h00;
						repeat_tick = 1'b1;
					end
					else
						step_d = step_q + 8'h01;
				end
			end
			default: st_d = LSC_IDLE;
		endcase
		// no tick may escape in the cycle that turns repetition off
		if (off || !meas_enable || cmd_q[0])
		begin
			st_d = LSC_IDLE;
			repeat_tick = 1'b0;
		end
		if (srst_q)
		begin
			st_d = LSC_IDLE;
			agc_d = 20'h00000;
		end
	end

	// base-unit prescaler for the auto-gain countdown
	always_comb
	begin
		base_d = base_q;
		if (agc_q != 20'h00000)
		begin
			base_d = (base_q + 8'h01 >= 8'(BASE_CYC)) ? 8'h00 : base_q + 8'h01;
		end
		else
			base_d = 8'h00;
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= LSC_IDLE;
			unit_q <= 40'h0;
			step_q <= 8'h00;
			agc_q <= 20'h00000;
			base_q <= 8'h00;
			restart_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			unit_q <= unit_d;
			step_q <= step_d;
			restart_q <= restart_d;
			base_q <= base_d;
			agc_q <= agc_d;
		end
	end

	// checks
	max_gain_cap_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		gain_applied <= cfg_q.max_gain) else $error("gain above ceiling");
	reduce_gain_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		predict_mode && gain_request <= cfg_q.gain_reduction |-> gain_applied == 4'h0)
		else $error("prediction reduction missing");
	resid_shift_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		flicker_word == (flicker_raw >> cfg_q.dropped_residual_count))
		else $error("residual shift wrong");
	agc_hi_read_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		rd_en && addr == `LSC_OFF_AGC_HI |=> rdata[7:3] == 5'h00)
		else $error("agc high reserved bits set");
	agc_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		agc_start && !agc_busy && !srst_q |=> agc_q == $past(agc_len))
		else $error("agc time not loaded");
	rate_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		cfg_q.repeat_rate_select == LSC_RATE_OFF |-> !repeat_tick)
		else $error("tick while off");
	vsync_arm_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		st_q == LSC_ARM && !vsync_pulse && meas_enable && !cmd_q[0] && !srst_q
		&& cfg_q.repeat_rate_select == $past(cfg_q.repeat_rate_select)
		|=> st_q == LSC_ARM) else $error("armed counting left early");
	soft_reset_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wr_cmd && wdata[`LSC_CMD_SOFT_RESET] && oscillator_power_on |=> soft_reset_req ##1
		cfg_q.max_gain == `LSC_RST_MAX_GAIN && !soft_reset_req)
		else $error("soft reset failed");
	flush_pulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wr_cmd && wdata[1] |=> queue_flush ##1 (!queue_flush || wr_cmd))
		else $error("flush not a pulse");
	wake_restart_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wake_from_irq_sleep && meas_enable |=> measure_restart)
		else $error("no restart after wake");
	tick_cov: cover property (@(posedge clk_sys) disable iff (!arst_n) repeat_tick);
	agc_cov: cover property (@(posedge clk_sys) disable iff (!arst_n) $fell(agc_busy));
	vsync_cov: cover property (@(posedge clk_sys) disable iff (!arst_n)
		st_q == LSC_ARM ##1 st_q == LSC_COUNT);
	srst_cov: cover property (@(posedge clk_sys) disable iff (!arst_n) soft_reset_req);
endmodule

// File: include/lsc_map.svh
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH
// register byte offsets
`define LSC_OFF_GAIN 8'ha9
`define LSC_OFF_RESID 8'haa
`define LSC_OFF_AGC_LO 8'hac
`define LSC_OFF_AGC_HI 8'had
`define LSC_OFF_REPEAT 8'hae
`define LSC_OFF_CMD 8'hb1
// reset values
`define LSC_RST_MAX_GAIN 4'hc
`define LSC_RST_GAIN_RED 4'h4
// command bit positions
`define LSC_CMD_SOFT_RESET 3
`define LSC_CMD_QUEUE_FLUSH 1
`define LSC_CMD_WAKE 0
// time units in 10 ns clock cycles, rounded up to whole cycles
// given directly: the picosecond figures overflow 32-bit integer arithmetic
`define LSC_BASE_CYC 139
`define LSC_FAST_CYC 8889
`define LSC_FASTLONG_CYC 142200
`define LSC_NORMAL_CYC 284400
`define LSC_LONG_CYC 4551100
`endif

// File: include/lsc_pkg.sv
package lsc_pkg;
	typedef enum logic [2:0] {
		LSC_RATE_OFF,
		LSC_RATE_NORMAL,
		LSC_RATE_LONG,
		LSC_RATE_FAST,
		LSC_RATE_FASTLONG,
		LSC_RATE_VSYNC,
		LSC_RATE_RSV6,
		LSC_RATE_RSV7
	} lsc_rate_type;
	typedef enum {LSC_IDLE, LSC_ARM, LSC_COUNT} lsc_state_type;
	typedef struct packed {
		logic [3:0] max_gain;
		logic [3:0] gain_reduction;
		logic [1:0] dropped_residual_count;
		logic [10:0] auto_gain_sample_count;
		lsc_rate_type repeat_rate_select;
	} lsc_cfg_type;
endpackage

// File: testbench/test_lsc_regs.sv
`timescale 1ns/100ps
`include "lsc_map.svh"
module test_lsc_regs import lsc_pkg::*;;
	logic clk_sys, arst_n, wr_en, rd_en, predict_mode, agc_start, agc_busy;
	logic oscillator_power_on, meas_enable, vsync_start_sel, vsync_pulse, repeat_tick;
	logic queue_flush, wake_from_irq_sleep, measure_restart, soft_reset_req;
	logic [7:0] addr, wdata, rdata, sample_period, wait_step_count;
	logic [3:0] gain_request, gain_applied;
	logic [23:0] flicker_raw, flicker_word;
	int miscompares, total_checks, n;
	// expected tick spacing per rate code with two wait steps, vsync every 4 cycles
	int per_exp [1:5] = '{10, 14, 4, 6, 8};
	// short time units keep the repetition runs brief
	lsc_regs #(.BASE_CYC(2), .FAST_CYC(2), .FASTLONG_CYC(3), .NORMAL_CYC(5), .LONG_CYC(7)) DUT (
		.clk_sys(clk_sys), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .gain_request(gain_request),
		.predict_mode(predict_mode), .gain_applied(gain_applied), .flicker_raw(flicker_raw),
		.flicker_word(flicker_word), .sample_period(sample_period), .agc_start(agc_start),
		.agc_busy(agc_busy), .oscillator_power_on(oscillator_power_on),
		.meas_enable(meas_enable), .vsync_start_sel(vsync_start_sel),
		.vsync_pulse(vsync_pulse), .wait_step_count(wait_step_count),
		.repeat_tick(repeat_tick), .queue_flush(queue_flush),
		.wake_from_irq_sleep(wake_from_irq_sleep), .measure_restart(measure_restart),
		.soft_reset_req(soft_reset_req));
	// clock generator
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// free-running vsync, one pulse every 4 cycles
	initial
	begin
		vsync_pulse = 1'b0;
		forever
		begin
			repeat (3) @(posedge clk_sys);
			vsync_pulse <= 1'b1;
			@(posedge clk_sys);
			vsync_pulse <= 1'b0;
		end
	end
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// every bus task starts and ends just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		// a strobe just lowered by the previous write gets one idle edge first
		if (wr_en === 1'b1)
			@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		@(negedge clk_sys);
		chk("read data", {16'h0000, exp}, {16'h0000, rdata});
		@(posedge clk_sys);
	endtask
	// pulses are collected over a few cycles since their exact slot may differ
	task automatic cmd(input logic [7:0] d, input logic [3:0] exp);
		logic [3:0] seen;
		seen = 4'h0;
		wr(`LSC_OFF_CMD, d);
		repeat (4)
		begin
			@(negedge clk_sys);
			seen = seen | {soft_reset_req, measure_restart, wake_from_irq_sleep, queue_flush};
		end
		chk("command pulses", {20'h0, exp}, {20'h0, seen});
		chk("pulses idle", 24'h0, {20'h0, soft_reset_req, measure_restart,
			wake_from_irq_sleep, queue_flush});
		@(posedge clk_sys);
	endtask
	// negedges up to and including the next one that sees the pin high; bounded
	task automatic gap(input bit on_vsync);
		n = 0;
		do
		begin
			@(negedge clk_sys);
			n++;
		end
		while ((on_vsync ? vsync_pulse : repeat_tick) !== 1'b1 && n < 300);
		if (n >= 300)
		begin
			miscompares++;
			$display("CHECK FAILED pulse wait expected high seen %b", on_vsync ? vsync_pulse
				: repeat_tick);
			wrap_up();
		end
	endtask
	// the first tick may sit anywhere in a period, so measure the one after it
	task automatic period(input int exp);
		gap(1'b0);
		gap(1'b0);
		chk("repeat period", 24'(exp), 24'(n));
		@(posedge clk_sys);
	endtask
	// main sequence
	initial
	begin
		miscompares = 0;
		total_checks = 0;
		arst_n = 1'b0;
		{addr, wdata, wr_en, rd_en, agc_start, predict_mode} = '0;
		{meas_enable, vsync_start_sel, oscillator_power_on} = '0;
		gain_request = 4'hf;
		flicker_raw = 24'habcdef;
		sample_period = 8'h01;
		wait_step_count = 8'h02;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		rd(`LSC_OFF_GAIN, 8'hc4);
		chk("gain cap", 24'hc, gain_applied);
		foreach (per_exp[k])
			rd(8'ha9 + 8'(k), 8'h00);
		rd(8'hb0, 8'h00);
		wr(`LSC_OFF_AGC_HI, 8'hff);
		rd(`LSC_OFF_AGC_HI, 8'h07);
		wr(`LSC_OFF_REPEAT, 8'hf8);
		rd(`LSC_OFF_REPEAT, 8'h00);
		// ceiling 8, reduction 3: plain, reduced then capped, reduced, saturated
		wr(`LSC_OFF_GAIN, 8'h83);
		for (int k = 0; k < 4; k++)
		begin
			gain_request <= k == 2 ? 4'h5 : k == 3 ? 4'h2 : 4'hf;
			predict_mode <= k != 0;
			@(negedge clk_sys);
			chk("gain applied", k == 2 ? 24'h2 : k == 3 ? 24'h0 : 24'h8, gain_applied);
			@(posedge clk_sys);
		end
		for (int k = 0; k < 4; k++)
		begin
			wr(`LSC_OFF_RESID, 8'hfc | 8'(k));
			rd(`LSC_OFF_RESID, 8'(k));
			chk("flicker word", 24'habcdef >> k, flicker_word);
		end
		// auto-gain count 1, sample setting 1: (1+1)*(1+1)*2 cycles
		wr(`LSC_OFF_AGC_LO, 8'h01);
		wr(`LSC_OFF_AGC_HI, 8'h00);
		rd(`LSC_OFF_AGC_LO, 8'h01);
		agc_start <= 1'b1;
		@(posedge clk_sys);
		agc_start <= 1'b0;
		n = 0;
		for (int i = 0; i < 100; i++)
		begin
			@(negedge clk_sys);
			n += int'(agc_busy === 1'b1);
		end
		chk("agc busy cycles", 24'd8, 24'(n));
		@(posedge clk_sys);
		meas_enable <= 1'b1;
		for (int k = 1; k <= 5; k++)
		begin
			wr(`LSC_OFF_REPEAT, 8'(k));
			period(per_exp[k]);
		end
		// restart from off with vsync wait: first tick one full period after the
		// first vsync seen once armed, spacing unchanged after that
		vsync_start_sel <= 1'b1;
		wr(`LSC_OFF_REPEAT, 8'h00);
		wr(`LSC_OFF_REPEAT, 8'h03);
		@(posedge clk_sys);
		gap(1'b1);
		gap(1'b0);
		chk("armed first tick", 24'(per_exp[3]), 24'(n));
		period(per_exp[3]);
		wr(`LSC_OFF_REPEAT, 8'h06);
		n = 0;
		repeat (60)
		begin
			@(negedge clk_sys);
			n += int'(repeat_tick !== 1'b0);
		end
		chk("reserved rate ticks", 24'd0, 24'(n));
		@(posedge clk_sys);
		cmd(8'h02, 4'h1);
		cmd(8'h01, 4'h6);
		meas_enable <= 1'b0;
		cmd(8'h01, 4'h2);
		rd(`LSC_OFF_CMD, 8'h00);
		// soft reset is ignored while the oscillator is off
		wr(`LSC_OFF_GAIN, 8'h11);
		cmd(8'h08, 4'h0);
		rd(`LSC_OFF_GAIN, 8'h11);
		oscillator_power_on <= 1'b1;
		cmd(8'h08, 4'h8);
		rd(`LSC_OFF_GAIN, 8'hc4);
		rd(`LSC_OFF_REPEAT, 8'h00);
		wrap_up();
	end
endmodule
